// file: pkg/gdc_pkg.sv
package gdc_pkg;
  // Request codes in the low six bits of a first byte
  localparam logic [5:0] REQ_SET_CFG0  = 6'h01;
  localparam logic [5:0] REQ_GET_CFG0  = 6'h02;
  localparam logic [5:0] REQ_SET_ILIM  = 6'h03;
  localparam logic [5:0] REQ_GET_ILIM  = 6'h04;
  localparam logic [5:0] REQ_SET_CFG2  = 6'h07;
  localparam logic [5:0] REQ_GET_CFG2  = 6'h08;
  // Reply first byte flags
  localparam int         ACK_BIT       = 6;
  localparam int         UNSOL_BIT     = 7;
  // Status register 0 unsolicited code
  localparam logic [7:0] UNSOL_STATUS0 = 8'h85;
  // Configuration register 0 fields
  localparam int         CFG0_UVLO_DIS = 3;
  localparam int         CFG0_OC_DIS   = 2;
  localparam int         CFG0_OC_LIM_H = 1;
  localparam int         CFG0_OC_LIM_L = 0;
  localparam logic [3:0] CFG0_MASK     = 4'hF;
  // Configuration register 2 fields
  localparam int         CFG2_DEAD_H   = 3;
  localparam int         CFG2_DEAD_L   = 2;
  localparam int         CFG2_BLANK_H  = 1;
  localparam int         CFG2_BLANK_L  = 0;
  localparam logic [3:0] CFG2_MASK     = 4'hF;
  // Reset values
  localparam logic [7:0] CFG0_RESET    = 8'h00;
  localparam logic [7:0] ILIM_RESET    = 8'h00;
  localparam logic [7:0] CFG2_RESET    = 8'h00;
  // Register file addresses
  localparam logic [1:0] ADDR_CFG0     = 2'h0;
  localparam logic [1:0] ADDR_ILIM     = 2'h1;
  localparam logic [1:0] ADDR_CFG2     = 2'h2;
  // Handler states, Gray coded in declaration order
  typedef enum logic [1:0]
  {
    GDC_IDLE = 2'b00,
    GDC_ARG  = 2'b01,
    GDC_RPL1 = 2'b11,
    GDC_RPL2 = 2'b10
  } gdc_state_t;
endpackage

// file: hdl/gdc_regs.sv
`timescale 1ns/1ps
// Small register file holding the three configuration bytes; read data registered
module gdc_regs
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read side
  input  wire logic [1:0] rd_addr,
  output logic      [7:0] rd_data,
  // Live contents
  output logic      [7:0] cfg0,
  output logic      [7:0] ilim,
  output logic      [7:0] cfg2
);
  import gdc_pkg::*;

  typedef struct packed
  {
    logic [7:0] cfg0;
    logic [7:0] ilim;
    logic [7:0] cfg2;
    logic [7:0] rd;
  } gdc_regs_st_t;

  gdc_regs_st_t r;
  gdc_regs_st_t next_r;

  // Masked writes keep unused bits at zero
  always_comb
  begin
    next_r = r;
    if (wr_en && wr_addr == ADDR_CFG0)
      next_r.cfg0 = {4'h0, wr_data[3:0] & CFG0_MASK};
    else if (wr_en && wr_addr == ADDR_ILIM)
      next_r.ilim = wr_data;
    else if (wr_en && wr_addr == ADDR_CFG2)
      next_r.cfg2 = {4'h0, wr_data[3:0] & CFG2_MASK}; // [R13]
    if (rd_addr == ADDR_CFG0)
      next_r.rd = r.cfg0;
    else if (rd_addr == ADDR_ILIM)
      next_r.rd = r.ilim;
    else if (rd_addr == ADDR_CFG2)
      next_r.rd = r.cfg2;
    else
      next_r.rd = 8'h00;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      r <= {CFG0_RESET, ILIM_RESET, CFG2_RESET, 8'h00};
    else
      r <= next_r;
  end

  assign rd_data = r.rd;
  assign cfg0    = r.cfg0;
  assign ilim    = r.ilim;
  assign cfg2    = r.cfg2;
endmodule

// file: hdl/gdc_msg.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Config 0 bit 3 at 0 keeps undervoltage lockout on, at 1 turns it off.
// R2: Config 0 bit 2 at 0 keeps transistor overcurrent detection on, at 1 turns it off.
// R3: Config 0 bits 1:0 pick the overcurrent threshold 0.25, 0.5, 0.75 or 1.0 V.
// R4: A set current-limit request is answered 43H when taken and 03H when refused.
// R5: The current-limit code is one unsigned byte, 0.991 V plus 13.77 mV per count.
// R6: A get current-limit request is answered 44H or 04H, then the stored code.
// R7: A set config 2 request is answered 47H when taken and 07H when refused.
// R8: Config 2 bits 3:2 pick dead time 2 us, 1 us, 500 ns or 250 ns.
// R9: Config 2 bits 1:0 pick blanking time 4 us, 2 us, 1 us or 500 ns.
// R10: A get config 2 request is answered 48H or 08H, then the register in write layout.
// R11: Messages sent without a request carry bit 7 set in the first byte, such as 85H.
// R12: Each reply's first byte is the request code with bit 6 set for ack, clear for nack.
// R13: Config 2 bits 7:4 are ignored on write and read as zero.
module gdc_msg
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Received bytes from the link deframer
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  // Bytes to the link framer
  output logic            tx_valid,
  output logic      [7:0] tx_byte,
  input  wire logic       tx_ready,
  // Unsolicited status request and its value
  input  wire logic       status0_event,
  input  wire logic [7:0] status0_value,
  // Settings driven into the protection and driver logic
  output logic            uvlo_disable,
  output logic            oc_detect_disable,
  output logic      [1:0] oc_limit_sel,
  output logic      [7:0] ilim_code,
  output logic      [1:0] dead_time_sel,
  output logic      [1:0] blank_time_sel
);
  import gdc_pkg::*;

  typedef struct packed
  {
    gdc_state_t st;
    logic [5:0] req;
    logic       ack;
    logic       two;
    logic       unsol;
    logic [7:0] unsol_val;
    logic       pend;
    logic       tx_valid;
    logic [7:0] tx_byte;
    logic [7:0] outs;
    logic [7:0] ilim;
  } gdc_msg_st_t;

  gdc_msg_st_t s;
  gdc_msg_st_t next_s;

  logic       wr_en;
  logic [1:0] wr_addr;
  logic [7:0] rd_data;
  logic [1:0] rd_addr;
  logic [7:0] cfg0;
  logic [7:0] ilim;
  logic [7:0] cfg2;

  gdc_regs u_regs
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (rx_byte),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .cfg0    (cfg0),
    .ilim    (ilim),
    .cfg2    (cfg2)
  );

  // Register address from the request being served
  always_comb
  begin
    if (s.req == REQ_SET_CFG0 || s.req == REQ_GET_CFG0)
      rd_addr = ADDR_CFG0;
    else if (s.req == REQ_SET_ILIM || s.req == REQ_GET_ILIM)
      rd_addr = ADDR_ILIM;
    else
      rd_addr = ADDR_CFG2;
  end
  assign wr_addr = rd_addr;
  // Set requests write on their argument byte
  assign wr_en = (s.st == GDC_ARG) && rx_valid;

  // Message sequencer: request byte, optional argument, then reply bytes
  always_comb
  begin
    next_s = s;
    next_s.outs = {cfg0[CFG0_UVLO_DIS], cfg0[CFG0_OC_DIS],          // [R1] [R2]
                   cfg0[CFG0_OC_LIM_H:CFG0_OC_LIM_L],               // [R3]
                   cfg2[CFG2_DEAD_H:CFG2_DEAD_L],                   // [R8]
                   cfg2[CFG2_BLANK_H:CFG2_BLANK_L]};                // [R9]
    next_s.ilim = ilim;                                             // [R5]
    if (status0_event)
    begin
      next_s.pend      = 1'b1;
      next_s.unsol_val = status0_value;
    end
    if (s.tx_valid && tx_ready)
      next_s.tx_valid = 1'b0;
    case (s.st)
      GDC_IDLE:
        if (rx_valid)
        begin
          next_s.req = rx_byte[5:0];
          next_s.unsol = 1'b0;
          // Unknown codes or set bits 7:6 are refused
          next_s.ack = (rx_byte[7:6] == 2'b00) &&
                       (rx_byte[5:0] == REQ_SET_CFG0 || rx_byte[5:0] == REQ_GET_CFG0 ||
                        rx_byte[5:0] == REQ_SET_ILIM || rx_byte[5:0] == REQ_GET_ILIM ||
                        rx_byte[5:0] == REQ_SET_CFG2 || rx_byte[5:0] == REQ_GET_CFG2);
          next_s.two = rx_byte[5:0] == REQ_GET_CFG0 || rx_byte[5:0] == REQ_GET_ILIM ||
                       rx_byte[5:0] == REQ_GET_CFG2;
          if (rx_byte[7:6] == 2'b00 && (rx_byte[5:0] == REQ_SET_CFG0 ||
              rx_byte[5:0] == REQ_SET_ILIM || rx_byte[5:0] == REQ_SET_CFG2))
            next_s.st = GDC_ARG;
          else
            next_s.st = GDC_RPL1;
        end
        else if (s.pend || status0_event)
        begin
          next_s.unsol = 1'b1;
          next_s.pend  = 1'b0;
          next_s.unsol_val = status0_event ? status0_value : s.unsol_val;
          next_s.st    = GDC_RPL1;
        end
      GDC_ARG:
        if (rx_valid)
          next_s.st = GDC_RPL1;                                     // [R4] [R7]
      GDC_RPL1:
        if (!s.tx_valid || tx_ready)
        begin
          next_s.tx_valid = 1'b1;
          if (s.unsol)
            next_s.tx_byte = UNSOL_STATUS0;                         // [R11]
          else
            next_s.tx_byte = {1'b0, s.ack, s.req};                  // [R12] [R4] [R7]
          next_s.st = (s.unsol || (s.two && s.ack)) ? GDC_RPL2 : GDC_IDLE;
        end
      GDC_RPL2:
        if (tx_ready)
        begin
          next_s.tx_valid = 1'b1;
          next_s.tx_byte  = s.unsol ? s.unsol_val : rd_data;        // [R6] [R10] [R13]
          next_s.st       = GDC_IDLE;
        end
      default:
        next_s.st = GDC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '{st: GDC_IDLE, ilim: ILIM_RESET, default: '0};
    else
      s <= next_s;
  end

  assign tx_valid          = s.tx_valid;
  assign tx_byte           = s.tx_byte;
  assign uvlo_disable      = s.outs[7];
  assign oc_detect_disable = s.outs[6];
  assign oc_limit_sel      = s.outs[5:4];
  assign dead_time_sel     = s.outs[3:2];
  assign blank_time_sel    = s.outs[1:0];
  assign ilim_code         = s.ilim;

  // Checks
  ack_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s.st == GDC_RPL1 && !s.unsol && (!s.tx_valid || tx_ready) |=> tx_byte[7] == 1'b0 && tx_valid) // [R12]
    else $error("reply first byte has bit 7 set");
  unsol_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s.st == GDC_RPL1 && s.unsol && (!s.tx_valid || tx_ready) |=> tx_byte == UNSOL_STATUS0) // [R11]
    else $error("unsolicited byte wrong");
  cfg2_high_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg2[7:4] == 4'h0) // [R13]
    else $error("config 2 upper bits not zero");
  dead_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    dead_time_sel == $past(cfg2[3:2])) // [R8]
    else $error("dead time select wrong");
  blank_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    blank_time_sel == $past(cfg2[1:0])) // [R9]
    else $error("blank time select wrong");
  uvlo_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    uvlo_disable == $past(cfg0[3]) && oc_detect_disable == $past(cfg0[2])) // [R1]
    else $error("uvlo or overcurrent enable wrong");
  oclim_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    oc_limit_sel == $past(cfg0[1:0])) // [R3]
    else $error("overcurrent limit wrong");
  ilim_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s.st == GDC_ARG && rx_valid && s.req == REQ_SET_ILIM |=> ##1 ilim_code == $past(rx_byte, 2)) // [R5]
    else $error("current limit code not stored");
  get_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s.st == GDC_RPL1 && !s.unsol && s.ack && s.req == REQ_GET_ILIM && (!s.tx_valid || tx_ready)
    |=> tx_byte == {2'b01, REQ_GET_ILIM}) // [R6]
    else $error("get current limit ack wrong");
  set_cov: cover property (@(posedge ref_clk) disable iff (!rstn) s.st == GDC_ARG && rx_valid);
  get_cov: cover property (@(posedge ref_clk) disable iff (!rstn) s.st == GDC_RPL2 && tx_ready);
  nack_cov: cover property (@(posedge ref_clk) disable iff (!rstn) s.st == GDC_RPL1 && !s.ack);
endmodule

// file: bench/gdc_host.sv
`timescale 1ns/1ps
// Host model on the far side of the handler's byte link
module gdc_host
(
  // Clock
  input  wire logic       ref_clk,
  // Request bytes to the handler
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  // Reply bytes from the handler
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  bit late;
  // Idle link at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b0;
  end
  // One byte per call; afterwards the line shows the inverse so a stale copy is never read
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~b;
  endtask
  // Takes one reply byte after stall idle cycles; a bounded wait flags a missing reply
  task automatic recv(input int stall, output logic [7:0] b);
    int n;
    n = 0;
    repeat (stall + 1) @(posedge ref_clk);
    tx_ready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (tx_valid !== 1'b1 && n < 40);
    late = (n >= 40);
    b = tx_byte;
    tx_ready <= 1'b0;
  endtask
endmodule

// file: bench/gdc_msg_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the configuration message handler
module gdc_msg_tb_top;
  import gdc_pkg::*;
  logic       ref_clk;
  logic       rstn;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       tx_valid;
  logic [7:0] tx_byte;
  logic       tx_ready;
  logic       status0_event;
  logic [7:0] status0_value;
  logic       uvlo_disable;
  logic       oc_detect_disable;
  logic [1:0] oc_limit_sel;
  logic [7:0] ilim_code;
  logic [1:0] dead_time_sel;
  logic [1:0] blank_time_sel;
  logic [7:0] v;
  logic [7:0] nk [6] = '{8'h05, 8'h00, 8'hC3, 8'h84, 8'hC7, 8'h48};
  int         error_cnt;
  int         samples_checked;
  int         cycles;

  gdc_msg i_dut (.ref_clk, .rstn, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .status0_event,
    .status0_value, .uvlo_disable, .oc_detect_disable, .oc_limit_sel, .ilim_code, .dead_time_sel, .blank_time_sel);
  gdc_host h (.ref_clk, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready);

  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One reply byte, with a missing reply counted as well
  task automatic rep(input int st, input logic [7:0] e, input string what);
    logic [7:0] b;
    h.recv(st, b);
    check("reply wait", {7'h0, h.late}, 8'h00);
    check(what, b, e);
  endtask

  task automatic pulse(input logic [7:0] val);
    @(posedge ref_clk);
    status0_event <= 1'b1;
    status0_value <= val;
    @(posedge ref_clk);
    status0_event <= 1'b0;
  endtask

  task automatic t_defaults;
    check("cfg0 out", {4'h0, uvlo_disable, oc_detect_disable, oc_limit_sel}, 8'h00);
    check("cfg2 out", {4'h0, dead_time_sel, blank_time_sel}, 8'h00);
    h.send({2'b00, REQ_GET_CFG2});
    rep(0, 8'h48, "get cfg2 ack");
    rep(0, 8'h00, "cfg2 reset");
    $display("test defaults done");
  endtask

  // Every combination of the four protection bits, with varied host stalls
  task automatic t_cfg0;
    for (int i = 0; i < 16; i++)
    begin
      h.send({2'b00, REQ_SET_CFG0});
      h.send(8'(i));
      rep(i % 3, 8'h41, "set cfg0 ack");
      repeat (2) @(posedge ref_clk);
      check("cfg0 out", {4'h0, uvlo_disable, oc_detect_disable, oc_limit_sel}, 8'(i));
      // Read back through the get request so its decode is exercised too
      h.send({2'b00, REQ_GET_CFG0});
      rep(0, 8'h42, "get cfg0 ack");
      rep(i % 2, 8'(i), "cfg0 read");
    end
    $display("test cfg0 done");
  endtask

  // Both ends of the code range and one middle value
  task automatic t_ilim;
    logic [7:0] c [3] = '{8'h00, 8'hFF, 8'hA5};
    foreach (c[j])
    begin
      h.send({2'b00, REQ_SET_ILIM});
      h.send(c[j]);
      rep(1, 8'h43, "set ilim ack");
      h.send({2'b00, REQ_GET_ILIM});
      rep(0, 8'h44, "get ilim ack");
      rep(2, c[j], "ilim read");
      check("ilim out", ilim_code, c[j]);
    end
    $display("test ilim done");
  endtask

  // Upper nibble written as ones must be dropped
  task automatic t_cfg2;
    for (int i = 0; i < 4; i++)
    begin
      v = {4'hF, 2'(i), ~2'(i)};
      h.send({2'b00, REQ_SET_CFG2});
      h.send(v);
      rep(0, 8'h47, "set cfg2 ack");
      h.send({2'b00, REQ_GET_CFG2});
      rep(0, 8'h48, "get cfg2 ack");
      rep(0, {4'h0, v[3:0]}, "cfg2 read");
      check("cfg2 out", {4'h0, dead_time_sel, blank_time_sel}, {4'h0, v[3:0]});
    end
    $display("test cfg2 done");
  endtask

  // Unknown codes and codes with bits 7:6 set get a one-byte refusal
  task automatic t_nack;
    foreach (nk[j])
    begin
      h.send(nk[j]);
      rep(0, {2'b00, nk[j][5:0]}, "nack");
    end
    $display("test nack done");
  endtask

  // Status while idle, then an event held back behind a slow reply
  task automatic t_unsol;
    pulse(8'h5A);
    rep(0, UNSOL_STATUS0, "unsol code");
    rep(0, 8'h5A, "unsol value");
    h.send({2'b00, REQ_GET_ILIM});
    pulse(8'h3C);
    rep(3, 8'h44, "get ilim ack");
    rep(0, 8'hA5, "ilim read");
    rep(0, UNSOL_STATUS0, "unsol code");
    rep(0, 8'h3C, "unsol value");
    $display("test unsolicited done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Main sequence
  initial
  begin
    rstn          = 1'b0;
    status0_event = 1'b0;
    status0_value = 8'h00;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_defaults();
    t_cfg0();
    t_ilim();
    t_cfg2();
    t_nack();
    t_unsol();
    report_and_stop();
  end
endmodule
